//--- hw/pin_mux_pkg.sv
// Purpose: Shared constants and types for the LCD pad function multiplexer.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Pad indices and reset values of the mode bits live here.

package pin_mux_pkg;

	// ****************************************
	// Pad layout
	// ****************************************
	localparam int NUM_PADS       = 20;
	localparam int LOW_PADS       = 15;
	localparam int IRQ_PAD_LO     = 15;
	localparam int SHARED_COM_LO  = 16;
	localparam int SHARED_COM_HI  = 18;
	localparam int IRQ_PAD_HI     = 19;

	// ****************************************
	// Reset values of the mode bits
	// ****************************************
	localparam logic LAYOUT_RST   = 1'b0;
	localparam logic IRQ_SEL_RST  = 1'b0;
	localparam logic POLARITY_RST = 1'b0;

	// Function chosen for one pad.
	typedef enum logic [3:0] {
		PAD_IDLE   = 4'h1,
		PAD_SEG    = 4'h2,
		PAD_COM    = 4'h4,
		PAD_IRQ    = 4'h8
	} pad_fn_t;

endpackage : pin_mux_pkg

//--- hw/pad_cfg_if.sv
// Purpose: Carries the mode bits between the mux top and its decoder.
// Assumes: Bits are registered by the top module.
// Notes:   One modport per side.

`timescale 1ns/100ps
`default_nettype none

interface pad_cfg_if;
	logic layout;
	logic irq_sel;
	logic [19:0] is_seg;
	logic [19:0] is_com;
	logic [19:0] is_irq;

	modport owner   (output layout, output irq_sel,
			input is_seg, input is_com, input is_irq);
	modport decoder (input layout, input irq_sel,
			output is_seg, output is_com, output is_irq);
endinterface : pad_cfg_if

`default_nettype wire

//--- hw/pad_fn_decode.sv
// Purpose: Decodes the layout and interrupt select bits into pad roles.
// Assumes: Inputs are registered mode bits.
// Notes:   Purely combinational.

`timescale 1ns/100ps
`default_nettype none

module pad_fn_decode
	import pin_mux_pkg::*;
(
	// Mode bits in, roles out.
	pad_cfg_if.decoder cfg
);

	// Role of each pad from the current mode.
	function automatic pad_fn_t pad_role(input int idx, input logic lay,
			input logic isel);
		pad_fn_t r;
		r = PAD_SEG;
		if (idx == IRQ_PAD_LO) begin
			r = (lay && isel) ? PAD_IRQ : PAD_SEG;
		end else if (idx >= SHARED_COM_LO && idx <= SHARED_COM_HI) begin
			r = lay ? PAD_COM : PAD_SEG;
		end else if (idx == IRQ_PAD_HI) begin
			if (lay)
				r = PAD_COM;
			else
				r = isel ? PAD_IRQ : PAD_SEG;
		end
		return r;
	endfunction : pad_role

	// One decoder per pad.
	genvar g;
	generate
		for (g = 0; g < NUM_PADS; g++) begin : g_pad
			pad_fn_t fn;
			assign fn = pad_role(g, cfg.layout, cfg.irq_sel);
			assign cfg.is_seg[g] = (fn == PAD_SEG);
			assign cfg.is_com[g] = (fn == PAD_COM);
			assign cfg.is_irq[g] = (fn == PAD_IRQ);
		end
	endgenerate

endmodule : pad_fn_decode

`default_nettype wire

//--- hw/lcd_key_irq_pin_mux.sv
// Purpose: Per-pad function select for a segment LCD driver with key scan.
// Assumes: Mode bits and pad levels come from logic on core_clk_i.
// Notes:   Key sense returns from pads pass three flip-flops.
// How it works
// - Pads 0 to 14 always drive segments, pulled down as keys during scan.
// - Layout 1, select 0: pad 15 is segment and pulled-down key.
// - Layout 1, select 1: pad 15 drives the interrupt instead.
// - Interrupt active low with polarity 0, active high with polarity 1.
// - Layout 0: pads 16 to 18 are segments and pulled-down keys.
// - Layout 1: pads 16 to 18 drive the upper common lines.
// - Layout 0, select 0: pad 19 is segment and pulled-down key.
// - After reset: four-common layout, commons low, segments inputs, pad 19 seg.
// - Standby: segments inputs, selected interrupt pad holds inactive level.

`timescale 1ns/100ps
`default_nettype none

module lcd_key_irq_pin_mux
	import pin_mux_pkg::*;
#(
	parameter int PADS = NUM_PADS
) (
	// Clock and reset.
	input  wire logic              core_clk_i,
	input  wire logic              reset_i,
	// Mode set and system state.
	input  wire logic              layout_i,
	input  wire logic              irq_sel_i,
	input  wire logic              polarity_i,
	input  wire logic              mode_load_i,
	input  wire logic              standby_i,
	input  wire logic              display_on_i,
	input  wire logic              key_scan_i,
	input  wire logic              irq_event_i,
	// Levels from the waveform generator.
	input  wire logic [PADS-1:0]   segment_drive_i,
	input  wire logic [PADS-1:0]   common_drive_i,
	// Pads.
	input  wire logic [PADS-1:0]   pad_in_i,
	output logic      [PADS-1:0]   pad_out_o,
	output logic      [PADS-1:0]   pad_oe_o,
	output logic      [PADS-1:0]   pad_pulldown_o,
	// Key sense and role report.
	output logic      [PADS-1:0]   key_sense_o,
	output logic      [PADS-1:0]   pad_is_com_o
);

	// ****************************************
	// Mode bits
	// ****************************************
	logic layout_r, layout_nxt;
	logic irq_sel_r, irq_sel_nxt;
	logic pol_r, pol_nxt;
	pad_cfg_if cfg ();

	// Mode bits load only on the mode set strobe, so a half-written
	// mode never reaches the pads.
	always_comb begin
		layout_nxt  = layout_r;
		irq_sel_nxt = irq_sel_r;
		pol_nxt     = pol_r;
		if (mode_load_i) begin
			layout_nxt  = layout_i;
			irq_sel_nxt = irq_sel_i;
			pol_nxt     = polarity_i;
		end
	end

	// Reset restores the four-common layout with pad 19 on segments.
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			layout_r  <= LAYOUT_RST;
			irq_sel_r <= IRQ_SEL_RST;
			pol_r     <= POLARITY_RST;
		end else begin
			layout_r  <= layout_nxt;
			irq_sel_r <= irq_sel_nxt;
			pol_r     <= pol_nxt;
		end
	end

	assign cfg.layout  = layout_r;
	assign cfg.irq_sel = irq_sel_r;

	pad_fn_decode u_dec (
		.cfg (cfg)
	);

	// ****************************************
	// Pad drive
	// ****************************************
	logic [PADS-1:0] out_nxt, oe_nxt, pd_nxt;
	logic [PADS-1:0] out_r, oe_r, pd_r;
	logic            run_r;
	logic            irq_level;

	// Asserted level follows the polarity bit; inactive is its inverse.
	// Standby masks the event, so the pad idles even if a late event
	// is still high when the device goes to sleep.
	assign irq_level = pol_r ? (irq_event_i && !standby_i)
			: !(irq_event_i && !standby_i);

	// Segments drive only while running and displaying; otherwise, except in key scan, they
	// float as inputs, which is also the state after reset.
	always_comb begin
		for (int i = 0; i < PADS; i++) begin
			out_nxt[i] = 1'b0;
			oe_nxt[i]  = 1'b0;
			pd_nxt[i]  = 1'b0;
			if (cfg.is_irq[i]) begin
				oe_nxt[i]  = 1'b1;
				out_nxt[i] = irq_level;
			end else if (cfg.is_com[i]) begin
				oe_nxt[i]  = 1'b1;
				out_nxt[i] = (run_r && !standby_i) ? common_drive_i[i]
						: 1'b0;
			end else if (cfg.is_seg[i]) begin
				pd_nxt[i]  = key_scan_i && !standby_i;
				oe_nxt[i]  = run_r && display_on_i && !standby_i
						&& !key_scan_i;
				out_nxt[i] = oe_nxt[i] & segment_drive_i[i];
			end
		end
	end

	// Pad registers; run_r stays low until the first cycle after reset
	// so the first driven value is never stale.
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			out_r <= '0;
			oe_r  <= '0;
			pd_r  <= '0;
			run_r <= 1'b0;
		end else begin
			out_r <= out_nxt;
			oe_r  <= oe_nxt;
			pd_r  <= pd_nxt;
			run_r <= 1'b1;
		end
	end

	assign pad_out_o      = out_r;
	assign pad_oe_o       = oe_r;
	assign pad_pulldown_o = pd_r;
	assign pad_is_com_o   = cfg.is_com;

	// ****************************************
	// Key sense synchroniser
	// ****************************************
	logic [PADS-1:0] ks_meta_r, ks_sync_r, key_nxt, key_r;

	// Pads are asynchronous, so only the second stage is used.
	always_comb begin
		key_nxt = ks_sync_r & pd_r;
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ks_meta_r <= '0;
			ks_sync_r <= '0;
			key_r     <= '0;
		end else begin
			ks_meta_r <= pad_in_i;
			ks_sync_r <= ks_meta_r;
			key_r     <= key_nxt;
		end
	end

	assign key_sense_o = key_r;

	// ****************************************
	// Checks
	// ****************************************
	a_low_pads_seg: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(cfg.is_seg[LOW_PADS-1:0] == '1))
		else $error("low pad lost segment role");
	a_p15_seg: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(layout_r && !irq_sel_r && key_scan_i && !standby_i)
		|=> pad_pulldown_o[IRQ_PAD_LO])
		else $error("pad 15 not keyed");
	a_p15_irq: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		$rose(layout_r && irq_sel_r)
		|=> pad_oe_o[IRQ_PAD_LO] && !pad_pulldown_o[IRQ_PAD_LO])
		else $error("pad 15 not irq");
	a_irq_pol: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		cfg.is_irq[IRQ_PAD_HI] && $stable(cfg.is_irq[IRQ_PAD_HI])
		##1 $stable(pol_r) && $stable(irq_event_i)
		|-> pad_out_o[IRQ_PAD_HI] == ($past(pol_r)
			~^ ($past(irq_event_i) && !$past(standby_i))))
		else $error("irq polarity wrong");
	a_mid_seg: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		!layout_r |-> cfg.is_seg[SHARED_COM_HI:SHARED_COM_LO] == 3'h7)
		else $error("pads 16-18 not segment");
	a_mid_com: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		layout_r && $stable(layout_r)
		|=> pad_oe_o[SHARED_COM_HI:SHARED_COM_LO] == 3'h7)
		else $error("pads 16-18 not common");
	a_p19_seg: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		!layout_r && !irq_sel_r |-> cfg.is_seg[IRQ_PAD_HI])
		else $error("pad 19 not segment");
	a_p19_other: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(!layout_r && irq_sel_r |-> cfg.is_irq[IRQ_PAD_HI])
		and (layout_r |-> cfg.is_com[IRQ_PAD_HI]))
		else $error("pad 19 role wrong");
	a_reset_state: assert property (
		@(posedge core_clk_i)
		$fell(reset_i) |-> pad_oe_o == '0 && !layout_r
			&& cfg.is_seg[IRQ_PAD_HI])
		else $error("reset state wrong");
	a_standby_in: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		standby_i ##1 standby_i |-> (pad_oe_o & $past(cfg.is_seg)) == '0)
		else $error("segment driven in standby");
	// The interrupt pad keeps driving its idle level through standby.
	a_irq_idle: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		standby_i && (cfg.is_irq != '0)
		|=> ((pad_oe_o & $past(cfg.is_irq)) == $past(cfg.is_irq))
			&& ((pad_out_o & $past(cfg.is_irq))
			== ($past(pol_r) ? '0 : $past(cfg.is_irq))))
		else $error("interrupt pad not idle in standby");
	// A key is only reported on a pad that had its pull-down applied.
	a_key_masked: assert property (
		@(posedge core_clk_i) disable iff (reset_i)
		(key_sense_o & ~$past(pad_pulldown_o)) == '0)
		else $error("key sensed on pad without pull-down");

endmodule : lcd_key_irq_pin_mux

`default_nettype wire

//--- sim/key_glass_model.sv
// Purpose: Glass and key switches seen from the pads.
// Assumes: A pressed key pulls its pad high against the pull-down.
// Notes:   A pad nobody holds toggles so a stale level is never trusted.

`timescale 1ns/100ps
`default_nettype none

module key_glass_model (
	input  wire logic        clk_i,
	input  wire logic [19:0] pad_out_i,
	input  wire logic [19:0] pad_oe_i,
	input  wire logic [19:0] pad_pulldown_i,
	input  wire logic [19:0] key_down_i,
	output logic      [19:0] pad_level_o
);
	logic [19:0] last_r = '0;

	// Remember the last level so a floating pad can show its inverse.
	always_ff @(posedge clk_i) begin
		last_r <= pad_level_o;
	end

	// Driven pads win; pulled-down pads read the key; the rest float.
	always_comb begin
		for (int i = 0; i < 20; i++) begin
			if (pad_oe_i[i])
				pad_level_o[i] = pad_out_i[i];
			else if (pad_pulldown_i[i])
				pad_level_o[i] = key_down_i[i];
			else
				pad_level_o[i] = ~last_r[i];
		end
	end
endmodule : key_glass_model

`default_nettype wire

//--- sim/lcd_key_irq_pin_mux_tb.sv
// Purpose: Self-checking bench for the pad function multiplexer.
// Assumes: Mode bits settle two edges after the load pulse.
// Notes:   Segment drive is checked with the display on and off.

`timescale 1ns/100ps
`default_nettype none

module lcd_key_irq_pin_mux_tb;
	// ****************************************
	// Stimulus and observation
	// ****************************************
	logic        clk = 0, rst = 1, lay = 0, sel = 0, pol = 0, ld = 0;
	logic        stb = 0, scan = 0, ev = 0, disp = 1;
	logic [19:0] keys = '0, common_drive = '0, segment_drive = '0;
	logic [19:0] pin, pout, poe, ppd, ksen, pcom;
	int          n_errors = 0, cmp_count = 0, cyc = 0;

	lcd_key_irq_pin_mux dut (.core_clk_i(clk), .reset_i(rst),
		.layout_i(lay), .irq_sel_i(sel), .polarity_i(pol),
		.mode_load_i(ld), .standby_i(stb), .display_on_i(disp),
		.key_scan_i(scan), .irq_event_i(ev), .segment_drive_i(segment_drive),
		.common_drive_i(common_drive), .pad_in_i(pin), .pad_out_o(pout),
		.pad_oe_o(poe), .pad_pulldown_o(ppd), .key_sense_o(ksen),
		.pad_is_com_o(pcom));

	key_glass_model glass (.clk_i(clk), .pad_out_i(pout),
		.pad_oe_i(poe), .pad_pulldown_i(ppd), .key_down_i(keys),
		.pad_level_o(pin));

	initial begin
		forever #4 clk = ~clk;
	end

	// A hang is cut off well past the roughly 140 cycles the run needs.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic cmp(input logic [19:0] g, input logic [19:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic set_mode(input logic l, s, p);
		@(posedge clk);
		lay <= l;
		sel <= s;
		pol <= p;
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
		step(2);
	endtask : set_mode

	// Keys are sensed on every pulled-down pad, none on commons.
	task automatic t_scan(input logic l, input logic [19:0] e);
		set_mode(l, 0, 0);
		@(posedge clk);
		scan <= 1'b1;
		keys <= 20'hfffff;
		step(5);
		cmp(ppd, e);
		cmp(ksen, e);
		cmp(poe & ~pcom, 20'h0);
		@(posedge clk);
		scan <= 1'b0;
		keys <= 20'h0;
	endtask : t_scan

	// Interrupt pad level for each layout, polarity and event.
	task automatic t_irq(input logic l, p, e);
		int pad;
		pad = l ? 15 : 19;
		set_mode(l, 1, p);
		@(posedge clk);
		ev <= e;
		scan <= 1'b1;
		step(2);
		cmp(20'(pout[pad]), 20'(p ? e : !e));
		cmp(20'({poe[pad], ppd[pad]}), 20'h2);
		@(posedge clk);
		scan <= 1'b0;
		ev <= 1'b0;
	endtask : t_irq

	// Commons follow their drive, then fall to ground in standby.
	task automatic t_com;
		set_mode(1, 0, 0);
		@(posedge clk);
		common_drive <= 20'hfffff;
		step(2);
		cmp(pcom, 20'hf0000);
		cmp(pout & 20'hf0000, 20'hf0000);
		@(posedge clk);
		stb <= 1'b1;
		step(2);
		cmp(pout & 20'hf0000, 20'h0);
		@(posedge clk);
		stb <= 1'b0;
		common_drive <= 20'h0;
	endtask : t_com

	// In standby with layout 0 only the interrupt pad drives, at its idle level.
	task automatic t_stby;
		set_mode(0, 1, 0);
		@(posedge clk);
		stb <= 1'b1;
		step(2);
		cmp(poe, 20'h80000);
		cmp(pout, 20'h80000);
		set_mode(0, 1, 1);
		cmp(poe, 20'h80000);
		cmp(pout, 20'h0);
		@(posedge clk);
		ev <= 1'b1;
		step(2);
		cmp(pout, 20'h0);
		@(posedge clk);
		stb <= 1'b0;
		ev <= 1'b0;
	endtask : t_stby

	// Segments show their drive only while the display is on.
	task automatic t_seg;
		set_mode(0, 0, 0);
		@(posedge clk);
		segment_drive <= 20'h5a5a5;
		step(2);
		cmp(poe, 20'hfffff);
		cmp(pout, 20'h5a5a5);
		@(posedge clk);
		disp <= 1'b0;
		step(2);
		cmp(poe | pout, 20'h0);
		@(posedge clk);
		disp <= 1'b1;
		segment_drive <= 20'h0;
	endtask : t_seg

	// A reset in mid-run drops an interrupt layout back to segments.
	task automatic t_reset;
		set_mode(1, 1, 1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		step(1);
		cmp(poe | pout | ppd | pcom, 20'h0);
	endtask : t_reset

	task automatic stop_test;
		$display("errors=%0d compares=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		step(1);
		cmp(poe | pout | ppd | pcom, 20'h0);
		t_scan(0, 20'hfffff);
		t_scan(1, 20'h0ffff);
		for (int i = 0; i < 8; i++) begin
			t_irq(i[2], i[1], i[0]);
		end
		t_com();
		t_seg();
		t_stby();
		t_reset();
		stop_test();
	end
endmodule : lcd_key_irq_pin_mux_tb

`default_nettype wire
